/* design/rpdr_core.sv */
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module rpdr_core
#(
    parameter int NUM_TERM = 7,
    parameter int TICK = rpdr_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic run_cmd,
    input wire logic [NUM_TERM-1:0] term_in,
    output logic [15:0] freq_out,
    output logic drive_on
);

    // ======================================================
    // Registers
    rpdr_pkg::rpdr_cfg_s cfg;
    rpdr_pkg::rpdr_cfg_s next_cfg;
    logic [7:0] tfunc [NUM_TERM];
    logic [7:0] next_tfunc [NUM_TERM];
    logic [31:0] next_rdata;
    rpdr_pkg::rpdr_state_e state;
    rpdr_pkg::rpdr_state_e next_state;
    logic permit_in;
    logic run_lock;

    // Time clamp on write
    function automatic logic [15:0] clip(input logic [15:0] v,
                                         input logic [15:0] lim);
        clip = (v > lim) ? lim : v;
    endfunction

    // Frequency clamp between start and max
    function automatic logic [15:0] fclip(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        fclip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Register writes
    always_comb
    begin
        next_cfg = cfg;
        for (int i = 0; i < NUM_TERM; i++)
            next_tfunc[i] = tfunc[i];
        if (wr_en)
        begin
            case (addr)
                rpdr_pkg::OFF_CTRL:
                begin
                    next_cfg.policy = wdata[rpdr_pkg::CTRL_POLICY_BIT];
                    next_cfg.stop_mode =
                        wdata[rpdr_pkg::CTRL_STOP_LSB +: 2];
                    next_cfg.method = wdata[rpdr_pkg::CTRL_METHOD_LSB +: 2];
                end
                rpdr_pkg::OFF_TARGET: next_cfg.target = wdata[15:0];
                rpdr_pkg::OFF_MAXF: next_cfg.maxf = wdata[15:0];
                rpdr_pkg::OFF_STARTF: next_cfg.startf = wdata[15:0];
                rpdr_pkg::OFF_ACCT: next_cfg.acc_t = wdata[15:0];
                rpdr_pkg::OFF_DECT: next_cfg.dec_t = wdata[15:0];
                rpdr_pkg::OFF_QHALT:
                    next_cfg.qhalt_t = clip(wdata[15:0], rpdr_pkg::QHALT_MAX);
                rpdr_pkg::OFF_RISEF: next_cfg.rise_f = wdata[15:0];
                rpdr_pkg::OFF_RISET:
                    next_cfg.rise_t = clip(wdata[15:0], rpdr_pkg::RISET_MAX);
                rpdr_pkg::OFF_FALLF: next_cfg.fall_f = wdata[15:0];
                rpdr_pkg::OFF_FALLT:
                    next_cfg.fall_t = clip(wdata[15:0], rpdr_pkg::FALLT_MAX);
                default:
                begin
                    for (int i = 0; i < NUM_TERM; i++)
                        if (addr == rpdr_pkg::OFF_TFUNC + 8'(4 * i))
                            next_tfunc[i] = wdata[7:0];
                end
            endcase
        end
    end

    // Read mux, data in the cycle after the strobe
    always_comb
    begin
        next_rdata = '0;
        if (rd_en)
        begin
            case (addr)
                rpdr_pkg::OFF_CTRL:
                    next_rdata = {27'h0, cfg.method, cfg.stop_mode,
                                  cfg.policy};
                rpdr_pkg::OFF_TARGET: next_rdata = {16'h0, cfg.target};
                rpdr_pkg::OFF_MAXF: next_rdata = {16'h0, cfg.maxf};
                rpdr_pkg::OFF_STARTF: next_rdata = {16'h0, cfg.startf};
                rpdr_pkg::OFF_ACCT: next_rdata = {16'h0, cfg.acc_t};
                rpdr_pkg::OFF_DECT: next_rdata = {16'h0, cfg.dec_t};
                rpdr_pkg::OFF_QHALT: next_rdata = {16'h0, cfg.qhalt_t};
                rpdr_pkg::OFF_RISEF: next_rdata = {16'h0, cfg.rise_f};
                rpdr_pkg::OFF_RISET: next_rdata = {16'h0, cfg.rise_t};
                rpdr_pkg::OFF_FALLF: next_rdata = {16'h0, cfg.fall_f};
                rpdr_pkg::OFF_FALLT: next_rdata = {16'h0, cfg.fall_t};
                rpdr_pkg::OFF_STATUS:
                    next_rdata = {8'h0, permit_in, run_lock, drive_on,
                                  2'h0, state, freq_out};
                default:
                begin
                    for (int i = 0; i < NUM_TERM; i++)
                        if (addr == rpdr_pkg::OFF_TFUNC + 8'(4 * i))
                            next_rdata = {24'h0, tfunc[i]};
                end
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg <= '{policy: 1'b0, stop_mode: rpdr_pkg::STOP_COAST,
                     method: rpdr_pkg::METHOD_VF, target: '0,
                     maxf: rpdr_pkg::MAXF_RST,
                     startf: rpdr_pkg::STARTF_RST,
                     acc_t: rpdr_pkg::RAMPT_RST,
                     dec_t: rpdr_pkg::RAMPT_RST,
                     qhalt_t: rpdr_pkg::QHALT_RST,
                     rise_f: rpdr_pkg::HOLDF_RST,
                     rise_t: rpdr_pkg::HOLDT_RST,
                     fall_f: rpdr_pkg::HOLDF_RST,
                     fall_t: rpdr_pkg::HOLDT_RST};
            for (int i = 0; i < NUM_TERM; i++)
                tfunc[i] <= '0;
            rdata <= '0;
        end
        else
        begin
            cfg <= next_cfg;
            for (int i = 0; i < NUM_TERM; i++)
                tfunc[i] <= next_tfunc[i];
            rdata <= next_rdata;
        end
    end

    // ======================================================
    // Permit detection per terminal
    logic [NUM_TERM-1:0] term_permit;
    logic permit_ok;
    logic running;
    logic loss;
    logic dwell_ok;
    logic [15:0] rise_fc;
    logic [15:0] fall_fc;

    generate
        for (genvar g = 0; g < NUM_TERM; g++)
        begin : g_term
            assign term_permit[g] = term_in[g] &&
                (tfunc[g] == rpdr_pkg::FUNC_RUN_PERMIT);
        end
    endgenerate

    // Permit and stop triggers
    assign permit_in = |term_permit;
    assign permit_ok = !cfg.policy || permit_in;
    assign running = (state != rpdr_pkg::RPDR_IDLE) &&
                     (state != rpdr_pkg::RPDR_QHALT);
    assign loss = cfg.policy && !permit_in && running;
    assign dwell_ok = (cfg.method == rpdr_pkg::METHOD_VF);
    assign rise_fc = fclip(cfg.rise_f, cfg.startf, cfg.maxf);
    assign fall_fc = fclip(cfg.fall_f, cfg.startf, cfg.maxf);

    // ======================================================
    // Sequencer
    logic [15:0] freq;
    logic [15:0] next_freq;
    logic next_drive_on;
    logic rise_pend;
    logic next_rise_pend;
    logic fall_pend;
    logic next_fall_pend;
    logic next_run_lock;
    logic [15:0] hold_cnt;
    logic [15:0] next_hold_cnt;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] goal;
    logic [15:0] ramp_t;
    logic step;
    logic hold;

    assign tick = (tick_cnt == 32'(TICK - 1));
    assign hold = (state == rpdr_pkg::RPDR_RISE_HOLD) ||
                  (state == rpdr_pkg::RPDR_FALL_HOLD);
    assign freq_out = freq;

    // Goal and ramp time per state
    always_comb
    begin
        goal = cfg.target;
        ramp_t = cfg.acc_t;
        case (state)
            rpdr_pkg::RPDR_ACCEL:
                goal = rise_pend ? rise_fc : cfg.target;
            rpdr_pkg::RPDR_RUN:
                ramp_t = (cfg.target < freq) ? cfg.dec_t : cfg.acc_t;
            rpdr_pkg::RPDR_DECEL:
            begin
                goal = fall_pend ? fall_fc : '0;
                ramp_t = cfg.dec_t;
            end
            rpdr_pkg::RPDR_QHALT:
            begin
                goal = '0;
                ramp_t = cfg.qhalt_t;
            end
            default: goal = freq;
        endcase
    end

    rpdr_ramp #(.TICK(TICK)) u_ramp
    (
        .clk(clk),
        .reset_n(reset_n),
        .run(freq != goal && !hold),
        .period(ramp_t),
        .full_scale(cfg.maxf),
        .step(step)
    );

    // Next state, frequency and hold bookkeeping
    always_comb
    begin
        next_state = state;
        next_freq = freq;
        next_drive_on = drive_on;
        next_rise_pend = rise_pend;
        next_fall_pend = fall_pend;
        next_run_lock = run_lock && run_cmd;
        next_hold_cnt = hold ? hold_cnt + 16'(tick) : '0;
        if (step && freq != goal)
            next_freq = (freq < goal) ? freq + 16'h1 : freq - 16'h1;
        if (loss && cfg.stop_mode[1] == 1'b0)
        begin
            next_state = rpdr_pkg::RPDR_IDLE;
            next_freq = '0;
            next_drive_on = 1'b0;
        end
        else if (loss)
        begin
            next_state = rpdr_pkg::RPDR_QHALT;
        end
        else
        begin
            case (state)
                rpdr_pkg::RPDR_IDLE:
                    if (run_cmd && permit_ok && !run_lock)
                    begin
                        next_state = rpdr_pkg::RPDR_ACCEL;
                        next_drive_on = 1'b1;
                        next_rise_pend = dwell_ok && cfg.rise_t != '0 &&
                            cfg.rise_f != '0 && rise_fc < cfg.target;
                    end
                rpdr_pkg::RPDR_ACCEL:
                    if (!run_cmd)
                        next_state = rpdr_pkg::RPDR_DECEL;
                    else if (freq == goal)
                        next_state = rise_pend ? rpdr_pkg::RPDR_RISE_HOLD
                                               : rpdr_pkg::RPDR_RUN;
                rpdr_pkg::RPDR_RISE_HOLD:
                    if (!run_cmd)
                        next_state = rpdr_pkg::RPDR_DECEL;
                    else if (hold_cnt >= cfg.rise_t)
                    begin
                        next_state = rpdr_pkg::RPDR_ACCEL;
                        next_rise_pend = 1'b0;
                    end
                rpdr_pkg::RPDR_RUN:
                    if (!run_cmd)
                        next_state = rpdr_pkg::RPDR_DECEL;
                rpdr_pkg::RPDR_DECEL:
                    if (run_cmd)
                    begin
                        next_state = rpdr_pkg::RPDR_RUN;
                        next_rise_pend = 1'b0;
                    end
                    else if (fall_pend && freq == goal)
                        next_state = rpdr_pkg::RPDR_FALL_HOLD;
                    else if (freq == '0)
                    begin
                        next_state = rpdr_pkg::RPDR_IDLE;
                        next_drive_on = 1'b0;
                    end
                rpdr_pkg::RPDR_FALL_HOLD:
                    if (run_cmd)
                        next_state = rpdr_pkg::RPDR_RUN;
                    else if (hold_cnt >= cfg.fall_t)
                    begin
                        next_state = rpdr_pkg::RPDR_DECEL;
                        next_fall_pend = 1'b0;
                    end
                rpdr_pkg::RPDR_QHALT:
                    if (freq == '0)
                    begin
                        next_state = rpdr_pkg::RPDR_IDLE;
                        next_drive_on = 1'b0;
                        next_run_lock = run_cmd &&
                            cfg.stop_mode == rpdr_pkg::STOP_QHALT;
                    end
                default: next_state = rpdr_pkg::RPDR_IDLE;
            endcase
        end
        // Rise hold of a cut ramp is never carried into idle
        if (next_state == rpdr_pkg::RPDR_IDLE)
            next_rise_pend = 1'b0;
        // Fall hold armed only by a stop command
        if (next_state == rpdr_pkg::RPDR_DECEL &&
            state != rpdr_pkg::RPDR_DECEL && state != rpdr_pkg::RPDR_FALL_HOLD)
            next_fall_pend = dwell_ok && cfg.fall_t != '0 &&
                cfg.fall_f != '0 && fall_fc < freq;
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= rpdr_pkg::RPDR_IDLE;
            freq <= '0;
            drive_on <= 1'b0;
            rise_pend <= 1'b0;
            fall_pend <= 1'b0;
            run_lock <= 1'b0;
            hold_cnt <= '0;
            tick_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            freq <= next_freq;
            drive_on <= next_drive_on;
            rise_pend <= next_rise_pend;
            fall_pend <= next_fall_pend;
            run_lock <= next_run_lock;
            hold_cnt <= next_hold_cnt;
            tick_cnt <= (tick || !hold) ? '0 : tick_cnt + 32'h1;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_coast_cut;
        loss && cfg.stop_mode == rpdr_pkg::STOP_COAST
        |=> !drive_on && freq == '0;
    endproperty
    a_coast_cut: assert property (p_coast_cut)
        else $error("coast stop did not cut output");

    property p_gate;
        state == rpdr_pkg::RPDR_IDLE && cfg.policy && !permit_in
        |=> state == rpdr_pkg::RPDR_IDLE;
    endproperty
    a_gate: assert property (p_gate)
        else $error("run started without permit");

    property p_qhalt;
        loss && cfg.stop_mode[1] |=> state == rpdr_pkg::RPDR_QHALT;
    endproperty
    a_qhalt: assert property (p_qhalt)
        else $error("permit loss did not start quick halt");

    property p_lock;
        run_lock && run_cmd |=> state == rpdr_pkg::RPDR_IDLE;
    endproperty
    a_lock: assert property (p_lock)
        else $error("restart without fresh run command");

    property p_resume;
        state == rpdr_pkg::RPDR_IDLE && !run_lock && run_cmd && permit_ok
        |=> state == rpdr_pkg::RPDR_ACCEL && drive_on;
    endproperty
    a_resume: assert property (p_resume)
        else $error("run not resumed");

    property p_hold_flat;
        hold && $past(hold) |-> $stable(freq);
    endproperty
    a_hold_flat: assert property (p_hold_flat)
        else $error("frequency moved during hold");

    property p_no_rehold;
        state == rpdr_pkg::RPDR_DECEL ##1 state == rpdr_pkg::RPDR_RUN
        |-> !rise_pend;
    endproperty
    a_no_rehold: assert property (p_no_rehold)
        else $error("rise hold rearmed on reacceleration");

    property p_limits;
        cfg.qhalt_t <= rpdr_pkg::QHALT_MAX &&
        cfg.rise_t <= rpdr_pkg::RISET_MAX && cfg.fall_t <= rpdr_pkg::FALLT_MAX;
    endproperty
    a_limits: assert property (p_limits)
        else $error("time setting out of range");

    property p_skip;
        state == rpdr_pkg::RPDR_IDLE && cfg.rise_t == '0 |=> !rise_pend;
    endproperty
    a_skip: assert property (p_skip)
        else $error("zero-time hold not skipped");

endmodule

/* inc/rpdr_pkg.sv */
// ==========================================================
// Shared constants and types
package rpdr_pkg;

    // Timing: hold and ramp times count in tenths of a second
    localparam int CLK_PERIOD_NS = 25;
    localparam int TENTH_SEC_NS = 100000000;
    localparam int TICK_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;

    // Register word offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TARGET = 8'h04;
    localparam logic [7:0] OFF_MAXF = 8'h08;
    localparam logic [7:0] OFF_STARTF = 8'h0C;
    localparam logic [7:0] OFF_ACCT = 8'h10;
    localparam logic [7:0] OFF_DECT = 8'h14;
    localparam logic [7:0] OFF_QHALT = 8'h18;
    localparam logic [7:0] OFF_RISEF = 8'h1C;
    localparam logic [7:0] OFF_RISET = 8'h20;
    localparam logic [7:0] OFF_FALLF = 8'h24;
    localparam logic [7:0] OFF_FALLT = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2C;
    localparam logic [7:0] OFF_TFUNC = 8'h30;

    // Control register fields
    localparam int CTRL_POLICY_BIT = 0;
    localparam int CTRL_STOP_LSB = 1;
    localparam int CTRL_METHOD_LSB = 3;

    // Encodings
    localparam logic [7:0] FUNC_RUN_PERMIT = 8'h0D;
    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_QHALT = 2'h2;
    localparam logic [1:0] STOP_QHALT_RESUME = 2'h3;
    localparam logic [1:0] METHOD_VF = 2'h0;

    // Limits and reset values (0.01 Hz and 0.1 s units)
    localparam logic [15:0] QHALT_MAX = 16'h1770;
    localparam logic [15:0] RISET_MAX = 16'h0064;
    localparam logic [15:0] FALLT_MAX = 16'h0258;
    localparam logic [15:0] QHALT_RST = 16'h0032;
    localparam logic [15:0] HOLDF_RST = 16'h01F4;
    localparam logic [15:0] HOLDT_RST = 16'h0000;
    localparam logic [15:0] MAXF_RST = 16'h1770;
    localparam logic [15:0] STARTF_RST = 16'h0032;
    localparam logic [15:0] RAMPT_RST = 16'h0032;

    typedef enum logic [2:0] {
        RPDR_IDLE = 3'b000,
        RPDR_ACCEL = 3'b001,
        RPDR_RISE_HOLD = 3'b010,
        RPDR_RUN = 3'b011,
        RPDR_DECEL = 3'b100,
        RPDR_FALL_HOLD = 3'b101,
        RPDR_QHALT = 3'b110
    } rpdr_state_e;

    // Software settings
    typedef struct packed {
        logic policy;
        logic [1:0] stop_mode;
        logic [1:0] method;
        logic [15:0] target;
        logic [15:0] maxf;
        logic [15:0] startf;
        logic [15:0] acc_t;
        logic [15:0] dec_t;
        logic [15:0] qhalt_t;
        logic [15:0] rise_f;
        logic [15:0] rise_t;
        logic [15:0] fall_f;
        logic [15:0] fall_t;
    } rpdr_cfg_s;

endpackage

/* design/rpdr_ramp.sv */
`timescale 1ns/100ps
// ==========================================================
// Rate generator: one step pulse per frequency unit so that
// full scale is crossed in the given time (0.1 s units)
module rpdr_ramp
#(
    parameter int TICK = rpdr_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [15:0] period,
    input wire logic [15:0] full_scale,
    output logic step
);

    logic [40:0] acc;
    logic [40:0] next_acc;
    logic [40:0] limit;
    logic [40:0] sum;

    // Accumulate full scale, one step per limit crossed
    always_comb
    begin
        limit = 41'(period) * 41'(TICK);
        sum = acc + 41'(full_scale);
        next_acc = acc;
        step = 1'b0;
        if (!run)
        begin
            next_acc = '0;
        end
        else if (limit == '0)
        begin
            step = 1'b1; // Zero time: fastest rate
            next_acc = '0;
        end
        else if (sum >= limit)
        begin
            step = 1'b1;
            next_acc = (sum - limit >= limit) ? '0 : sum - limit;
        end
        else
        begin
            next_acc = sum;
        end
    end

    // Accumulator register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            acc <= '0;
        else
            acc <= next_acc;
    end

endmodule

/* sim/rpdr_partner.sv */
`timescale 1ns/100ps
// ==========================================
// Run command source and input terminals
module rpdr_partner
#(
    parameter int NUM_TERM = 7,
    parameter int PERMIT_IDX = 2
)
(
    input wire logic want_run,
    input wire logic want_permit,
    input wire logic [NUM_TERM-1:0] noise,
    output logic run_cmd,
    output logic [NUM_TERM-1:0] term_in
);
    // Unassigned terminals chatter, permit terminal follows request
    always_comb
    begin
        term_in = noise;
        term_in[PERMIT_IDX] = want_permit;
        run_cmd = want_run;
    end
endmodule

/* sim/rpdr_core_test.sv */
`timescale 1ns/100ps
// ==========================================
// Self-checking bench
module rpdr_core_test;
    logic clk, reset_n, wr_en, rd_en, rd_q, want_run, want_permit;
    logic run_cmd, drive_on;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, seed, mm;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] freq_out;
    logic [6:0] term_in, noise;
    int n_mismatch, n_compared, n;

    rpdr_core #(.NUM_TERM(7), .TICK(10)) u_rpdr_core (.clk(clk),
        .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .run_cmd(run_cmd),
        .term_in(term_in), .freq_out(freq_out), .drive_on(drive_on));
    rpdr_partner u_rpdr_partner (.want_run(want_run),
        .want_permit(want_permit), .noise(noise), .run_cmd(run_cmd),
        .term_in(term_in));

    // Clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic fail(input string m);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) fail(m);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= (rnd() & 32'hFFFF0000) | {16'h0000, d};
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task automatic set(input logic r, p);
        @(posedge clk);
        want_run <= r;
        want_permit <= p;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Waits for a frequency, leaves cycles spent in n
    task automatic wait_f(input logic [15:0] f, input int lim);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (freq_out !== f && n < lim);
        if (freq_out !== f) fail("frequency not reached");
    endtask

    // Terminal chatter
    always @(posedge clk)
        noise <= 7'(rnd());

    // Read data against oldest note
    always @(posedge clk)
    begin
        if (rd_q)
        begin
            mm = msk_q.pop_front();
            chk(rdata & mm, exp_q.pop_front() & mm, "read data");
        end
        rd_q <= rd_en;
    end

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        fail("watchdog");
        summarize();
    end

    // ==========================================
    // Scenarios
    initial
    begin
        seed = 32'h7EA6F943;
        {reset_n, wr_en, rd_en, rd_q, want_run, want_permit} = 6'h00;
        addr = 8'h00;
        wdata = 32'h00000000;
        noise = 7'h00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, unmapped place, saturation
        rd(rpdr_pkg::OFF_QHALT, 32'h00000032);
        rd(rpdr_pkg::OFF_RISEF, 32'h000001F4);
        rd(rpdr_pkg::OFF_FALLF, 32'h000001F4);
        rd(rpdr_pkg::OFF_RISET, 32'h00000000);
        rd(rpdr_pkg::OFF_FALLT, 32'h00000000);
        rd(rpdr_pkg::OFF_CTRL, 32'h00000000);
        rd(8'hFC, 32'h00000000);
        wr(rpdr_pkg::OFF_QHALT, 16'hFFFF);
        rd(rpdr_pkg::OFF_QHALT, 32'h00001770);
        wr(rpdr_pkg::OFF_RISET, 16'hFFFF);
        rd(rpdr_pkg::OFF_RISET, 32'h00000064);
        wr(rpdr_pkg::OFF_FALLT, 16'hFFFF);
        rd(rpdr_pkg::OFF_FALLT, 32'h00000258);
        wr(rpdr_pkg::OFF_QHALT, 16'h0001);
        wr(rpdr_pkg::OFF_ACCT, 16'h0000);
        wr(rpdr_pkg::OFF_DECT, 16'h0000);
        wr(rpdr_pkg::OFF_TARGET, 16'h0320);
        wr(rpdr_pkg::OFF_RISET, 16'h0002);
        wr(rpdr_pkg::OFF_FALLT, 16'h0002);
        // Rise hold then target
        set(1'b1, 1'b0);
        wait_f(16'h01F4, 700);
        cyc(12);
        rd(rpdr_pkg::OFF_STATUS, 32'h002201F4, 32'h0027FFFF);
        wait_f(16'h0320, 400);
        rd(rpdr_pkg::OFF_STATUS, 32'h00230320, 32'h0027FFFF);
        // Setpoint moves pass hold levels without holding
        wr(rpdr_pkg::OFF_TARGET, 16'h0100);
        wait_f(16'h0100, 700);
        chk(n <= 555, 1, "hold on setpoint fall");
        wr(rpdr_pkg::OFF_TARGET, 16'h0320);
        wait_f(16'h0320, 700);
        chk(n <= 555, 1, "hold on re-acceleration");
        // Stop with fall hold
        set(1'b0, 1'b0);
        wait_f(16'h01F4, 400);
        cyc(12);
        rd(rpdr_pkg::OFF_STATUS, 32'h002501F4, 32'h0027FFFF);
        wait_f(16'h0000, 600);
        cyc(2);
        chk(drive_on, 0, "drive after stop");
        // Zero hold frequency skips the hold
        wr(rpdr_pkg::OFF_RISEF, 16'h0000);
        set(1'b1, 1'b0);
        wait_f(16'h0320, 900);
        chk(n <= 810, 1, "zero frequency hold");
        set(1'b0, 1'b0);
        wait_f(16'h0000, 900);
        // Gated permit, coast
        wr(8'h38, 16'h000D);
        wr(rpdr_pkg::OFF_CTRL, 16'h0001);
        set(1'b1, 1'b0);
        cyc(30);
        chk(drive_on, 0, "run without permit");
        set(1'b1, 1'b1);
        wait_f(16'h0320, 900);
        set(1'b1, 1'b0);
        cyc(3);
        chk({drive_on, freq_out}, 0, "coast stop");
        // Quick halt, fresh run needed
        wr(rpdr_pkg::OFF_CTRL, 16'h0005);
        set(1'b1, 1'b1);
        wait_f(16'h0320, 900);
        set(1'b1, 1'b0);
        rd(rpdr_pkg::OFF_STATUS, 32'h00260000, 32'h00270000);
        wait_f(16'h0000, 900);
        set(1'b1, 1'b1);
        cyc(40);
        chk(drive_on, 0, "restart by permit alone");
        set(1'b0, 1'b1);
        set(1'b1, 1'b1);
        wait_f(16'h0320, 900);
        // Quick halt with resume
        wr(rpdr_pkg::OFF_CTRL, 16'h0007);
        set(1'b1, 1'b0);
        wait_f(16'h0000, 900);
        set(1'b1, 1'b1);
        wait_f(16'h0320, 900);
        // Stop mode 1 coasts; method 1 runs without dwell holds
        wr(rpdr_pkg::OFF_RISEF, 16'h01F4);
        wr(rpdr_pkg::OFF_CTRL, 16'h000B);
        set(1'b1, 1'b0);
        cyc(3);
        chk({drive_on, freq_out}, 0, "mode 1 coast stop");
        set(1'b1, 1'b1);
        wait_f(16'h0320, 900);
        chk(n <= 810, 1, "rise hold outside V/F");
        set(1'b0, 1'b1);
        wait_f(16'h0000, 900);
        chk(n <= 810, 1, "fall hold outside V/F");
        summarize();
    end
endmodule
